// file: hdl/ted_pkg.sv
// Purpose: shared constants and types of the tx_opportunity extension decoder
// Assumes: extension bodies arrive as one 32-bit word, octet 0 in bits 7:0
// Notes:   register offsets are byte addresses on the classic Wishbone slave
package ted_pkg;

    // extension word layout
    localparam int          EXT_TYPE_LSB   = 27;
    localparam int          EXT_TYPE_W     = 5;
    localparam logic [4:0]  TYPE_MAX_LEN   = 5'h03;
    localparam logic [4:0]  TYPE_NODE_LIST = 5'h04;
    localparam int          MAX_LEN_W      = 18;
    localparam int          POL_BIT        = 0;
    localparam int          FMT_BIT        = 1;
    localparam int          OCT1_LSB       = 8;
    localparam int          OCT2_LSB       = 16;
    localparam int          BITMAP_W       = 8;

    // node_identifier encodings
    localparam int          ID_W           = 8;
    localparam logic [8:0]  ID_LAST_NODE   = 9'h0FA;
    localparam logic [7:0]  ID_CLR_LAST    = 8'hFF;
    localparam logic [2:0]  IDX_BYTE_LAST  = 3'h1;
    localparam logic [2:0]  IDX_BIT_LAST   = 3'h7;

    // register map, byte addresses
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h4;
    localparam logic [3:0]  REG_MAX_LEN    = 4'h8;
    localparam logic [3:0]  REG_COUNT      = 4'hC;
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_CLR_BIT   = 1;
    localparam logic        CTRL_EN_RST    = 1'b1;
    localparam int          CNT_W          = 16;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CLEAR = 3'b010,
        ST_WRITE = 3'b100
    } ted_state_t;

endpackage

// file: hdl/ted_bitmem.sv
// Purpose: small one-write one-read memory holding the contention_slot list
// Assumes: read data appears one clock after the read address
// Notes:   no reset; contents are swept clear by the owner after reset
`timescale 1ns/1ps
module ted_bitmem #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 1
) (
    // clock
    input  wire logic              clk_i,
    // write port
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] waddr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    // read port
    input  wire logic [ADDR_W-1:0] raddr_i,
    output logic      [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

    if (ADDR_W < 1 || DATA_W < 1) begin : g_bad_size
        $error("ted_bitmem: widths must be at least one");
    end

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_reg[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_reg[raddr_i];
    end
endmodule // ted_bitmem

// file: hdl/ted_top.sv
// Purpose: decodes length-limit and node-list extensions of tx_opportunity descriptors
// Assumes: one extension body per accepted word; slot_start_i opens a new contention_slot
// Notes:   node list kept as one bit per node_identifier in ted_bitmem
//
// Contract
// - type field bits 31:27 equal three means length limit for shared_tx_window.
// - max_slot_tx_length taken from bits 17:0, in scheduling time units.
// - reserved bits are zero from sender; decoder ignores their value.
// - type field four decodes as contention_slot node list; octet 3 low bits reserved.
// - several node-list extensions of one slot merge into one list.
// - octet 0 bit 0: zero listed nodes may contend, one they must not.
// - octet 0 bit 1: zero byte-map entries, one bit-map entries.
// - byte map octets 1,2: 0 new nodes, 1-250 ids, 251-254 reserved, 255 skip.
// - bit map octet 1 is base: 0 new nodes, 1-250 ids, 251-255 reserved.
// - bit-map octet 2 bit k, when zero, lists node base plus k plus one.
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ted_top
    import ted_pkg::*;
#(
    parameter int WB_ADR_W = 4
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // classic Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [WB_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // extension stream from the MAP parser
    input  wire logic                 window_start_i,
    input  wire logic                 slot_start_i,
    input  wire logic                 ext_valid_i,
    input  wire logic [31:0]          ext_word_i,
    output logic                      ext_ready_o,
    // scheduler view
    output logic [MAX_LEN_W-1:0]      max_slot_tx_length_o,
    output logic                      max_len_valid_o,
    input  wire logic                 query_valid_i,
    input  wire logic [ID_W-1:0]      query_id_i,
    output logic                      query_done_o,
    output logic                      query_allow_o
);

    if (WB_ADR_W < 4) begin : g_bad_adr
        $error("ted_top: WB_ADR_W must be at least 4");
    end

    // fixed field positions: the type field closes the 32-bit word
    if (EXT_TYPE_LSB + EXT_TYPE_W != 32) begin : g_bad_type
        $error("ted_top: type field must end at bit 31");
    end

    // reserved bits sit between length and type, never inside either
    if (MAX_LEN_W > EXT_TYPE_LSB) begin : g_bad_len
        $error("ted_top: length field overlaps the type field");
    end

    // both list octets must lie below the type field
    if (OCT2_LSB + 8 > EXT_TYPE_LSB || OCT1_LSB + 8 > OCT2_LSB) begin : g_bad_oct
        $error("ted_top: list octets overlap");
    end

    // octet 0 carries the two list flags
    if (POL_BIT == FMT_BIT || FMT_BIT >= OCT1_LSB) begin : g_bad_flags
        $error("ted_top: polarity and format bits must be distinct bits of octet 0");
    end

    // one memory bit per node_identifier, every valid id needs an address
    if ((1 << ID_W) <= int'(ID_LAST_NODE)) begin : g_bad_id
        $error("ted_top: ID_W too narrow for the node_identifier range");
    end

    // the clear sweep must end on the last memory address
    if (int'(ID_CLR_LAST) != (1 << ID_W) - 1) begin : g_bad_sweep
        $error("ted_top: clear sweep does not cover the list memory");
    end

    // bit-map walk uses a 3-bit index that stops at IDX_BIT_LAST
    if (BITMAP_W != 8 || int'(IDX_BIT_LAST) != BITMAP_W - 1) begin : g_bad_map
        $error("ted_top: bit-map width must match the entry index");
    end

    // COUNT packs both counters into one 32-bit read word
    if (2 * CNT_W != 32) begin : g_bad_cnt
        $error("ted_top: counters must share one 32-bit word");
    end

    // offsets are decoded from address bits 3:2 only
    if (REG_CTRL[1:0] != 2'b00 || REG_STATUS[1:0] != 2'b00
        || REG_MAX_LEN[1:0] != 2'b00 || REG_COUNT[1:0] != 2'b00) begin : g_bad_off
        $error("ted_top: register offsets must be word aligned");
    end

    if (CTRL_EN_BIT == CTRL_CLR_BIT) begin : g_bad_ctrl
        $error("ted_top: enable and clear need their own CTRL bits");
    end

    typedef struct packed {
        ted_state_t           state;
        logic [ID_W-1:0]      clr_addr;
        logic [2:0]           idx;
        logic                 fmt;
        logic [7:0]           oct1;
        logic [7:0]           oct2;
        logic [MAX_LEN_W-1:0] max_len;
        logic                 max_len_valid;
        logic                 list_active;
        logic                 list_pol;
        logic                 enable;
        logic                 clr_req;
        logic [CNT_W-1:0]     named_cnt;
        logic [CNT_W-1:0]     drop_cnt;
        logic                 wb_ack;
        logic [31:0]          wb_dat;
        logic                 q_pend;
        logic                 q_done;
        logic                 q_allow;
    } ted_regs_t;

    ted_regs_t s_reg;
    ted_regs_t s_next;

    // memory ports
    logic            mem_we;
    logic [ID_W-1:0] mem_waddr;
    logic            mem_wdata;
    logic            mem_rdata;

    // entry under work in ST_WRITE
    logic [8:0]      cand_id;
    logic            cand_ok;
    logic            cand_last;
    logic [8:0]      bit_sum;

    // bus decode
    logic            wb_req;
    logic [3:0]      wb_off;
    logic [4:0]      ext_type;
    logic            ext_take;

    // address bits 1:0 are ignored; reads return a whole word, a CTRL write needs wb_sel_i[0]
    assign wb_req   = wb_cyc_i && wb_stb_i && !s_reg.wb_ack;
    assign wb_off   = {wb_adr_i[3:2], 2'b00};
    assign ext_type = ext_word_i[EXT_TYPE_LSB +: EXT_TYPE_W];

    // a new slot outranks an extension offered in the same cycle
    assign ext_ready_o = (s_reg.state == ST_IDLE) && !slot_start_i && !s_reg.clr_req;
    assign ext_take    = ext_ready_o && ext_valid_i;

    // candidate node_identifier for the current index
    always_comb begin
        bit_sum   = 9'({1'b0, s_reg.oct1}) + 9'({6'h00, s_reg.idx}) + 9'h001;
        cand_id   = 9'h000;
        cand_ok   = 1'b0;
        cand_last = 1'b0;
        if (!s_reg.fmt) begin
            // byte map: index 0 is octet 1, index 1 is octet 2
            cand_id   = (s_reg.idx == 3'h0) ? {1'b0, s_reg.oct1} : {1'b0, s_reg.oct2};
            cand_ok   = (cand_id <= ID_LAST_NODE);
            cand_last = (s_reg.idx == IDX_BYTE_LAST);
        end else begin
            cand_id   = bit_sum;
            // base above 250 is reserved, so nothing of this word names a node
            cand_ok   = ({1'b0, s_reg.oct1} <= ID_LAST_NODE)
                        && !s_reg.oct2[s_reg.idx]
                        && (bit_sum <= ID_LAST_NODE);
            cand_last = (s_reg.idx == IDX_BIT_LAST);
        end
    end

    // memory write side
    // sweep and list writes never share a cycle, so one write port serves both
    always_comb begin
        mem_we    = 1'b0;
        mem_waddr = s_reg.clr_addr;
        mem_wdata = 1'b0;
        unique case (s_reg.state)
            ST_CLEAR: begin
                mem_we    = 1'b1;
                mem_waddr = s_reg.clr_addr;
                mem_wdata = 1'b0;
            end
            ST_WRITE: begin
                // only setting bits, so repeated ids and later words merge
                mem_we    = cand_ok;
                mem_waddr = cand_id[ID_W-1:0];
                mem_wdata = 1'b1;
            end
            ST_IDLE: begin
                mem_we    = 1'b0;
            end
        endcase
    end

    ted_bitmem #(
        .ADDR_W (ID_W),
        .DATA_W (1)
    ) u_list (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (mem_wdata),
        .raddr_i (query_id_i),
        .rdata_o (mem_rdata)
    );

    // next state
    always_comb begin
        s_next        = s_reg;
        s_next.wb_ack = 1'b0;
        s_next.q_done = 1'b0;

        // scheduler query: memory read, then the verdict registered
        s_next.q_pend = query_valid_i;
        if (s_reg.q_pend) begin
            s_next.q_done  = 1'b1;
            // no list for this slot means everyone may contend
            s_next.q_allow = s_reg.list_active ? (mem_rdata ^ s_reg.list_pol) : 1'b1;
        end

        if (window_start_i) begin
            s_next.max_len_valid = 1'b0;
        end

        // a slot start while busy is kept and served once idle
        if (slot_start_i && s_reg.state != ST_IDLE) begin
            s_next.clr_req = 1'b1;
        end

        unique case (s_reg.state)
            ST_IDLE: begin
                if (slot_start_i || s_reg.clr_req) begin
                    s_next.state    = ST_CLEAR;
                    s_next.clr_addr = '0;
                    s_next.clr_req  = 1'b0;
                    // old list stops applying as soon as the sweep starts
                    s_next.list_active = 1'b0;
                    s_next.list_pol    = 1'b0;
                end else if (ext_take && s_reg.enable) begin
                    if (ext_type == TYPE_MAX_LEN) begin
                        // bits 26:18 are never looked at
                        s_next.max_len       = ext_word_i[MAX_LEN_W-1:0];
                        s_next.max_len_valid = 1'b1;
                    end else if (ext_type == TYPE_NODE_LIST) begin
                        // octet 0 bits 7:2 and octet 3 bits 2:0 ignored
                        s_next.list_active = 1'b1;
                        s_next.list_pol    = ext_word_i[POL_BIT];
                        s_next.fmt         = ext_word_i[FMT_BIT];
                        s_next.oct1        = ext_word_i[OCT1_LSB +: 8];
                        s_next.oct2        = ext_word_i[OCT2_LSB +: 8];
                        s_next.idx         = 3'h0;
                        s_next.state       = ST_WRITE;
                    end else begin
                        // other extension types are taken and dropped
                    end
                end
            end
            ST_CLEAR: begin
                // one address per cycle; ready stays low for the whole sweep
                s_next.clr_addr = s_reg.clr_addr + 8'h01;
                if (s_reg.clr_addr == ID_CLR_LAST) begin
                    s_next.state       = ST_IDLE;
                    s_next.named_cnt   = '0;
                    s_next.drop_cnt    = '0;
                end
            end
            ST_WRITE: begin
                if (cand_ok) begin
                    s_next.named_cnt = s_reg.named_cnt + 16'h0001;
                end else if (!s_reg.fmt && s_reg.oct1 != ID_CLR_LAST && s_reg.idx == 3'h0) begin
                    s_next.drop_cnt = s_reg.drop_cnt + 16'h0001;
                end else if (!s_reg.fmt && s_reg.oct2 != ID_CLR_LAST && s_reg.idx == 3'h1) begin
                    s_next.drop_cnt = s_reg.drop_cnt + 16'h0001;
                end
                s_next.idx = s_reg.idx + 3'h1;
                if (cand_last) begin
                    s_next.state = ST_IDLE;
                end
            end
        endcase

        // Wishbone slave, one wait state, every address answered
        // ack is registered and blocks wb_req, so a held stb gets an ack every second cycle
        if (wb_req) begin
            s_next.wb_ack = 1'b1;
            s_next.wb_dat = 32'h0000_0000;
            if (wb_we_i) begin
                if (wb_off == REG_CTRL && wb_sel_i[0]) begin
                    s_next.enable = wb_dat_i[CTRL_EN_BIT];
                    if (wb_dat_i[CTRL_CLR_BIT]) begin
                        s_next.clr_req = 1'b1;
                    end
                end
            end else begin
                unique case (wb_off)
                    REG_CTRL: begin
                        s_next.wb_dat[CTRL_EN_BIT] = s_reg.enable;
                    end
                    REG_STATUS: begin
                        s_next.wb_dat[4:0] = {s_reg.fmt, (s_reg.state != ST_IDLE),
                                              s_reg.list_pol, s_reg.list_active,
                                              s_reg.max_len_valid};
                    end
                    REG_MAX_LEN: begin
                        s_next.wb_dat[MAX_LEN_W-1:0] = s_reg.max_len;
                    end
                    REG_COUNT: begin
                        s_next.wb_dat = {s_reg.drop_cnt, s_reg.named_cnt};
                    end
                    default: begin
                        s_next.wb_dat = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // state register; reset sweeps the list memory clear first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg               <= '0;
            s_reg.state         <= ST_CLEAR;
            s_reg.enable        <= CTRL_EN_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o             = s_reg.wb_ack;
    assign wb_dat_o             = s_reg.wb_dat;
    assign max_slot_tx_length_o = s_reg.max_len;
    assign max_len_valid_o      = s_reg.max_len_valid;
    assign query_done_o         = s_reg.q_done;
    assign query_allow_o        = s_reg.q_allow;

endmodule // ted_top

// file: sim/ted_top_properties.sv
// Purpose: port-level checks of the extension decoder
// Assumes: bound to ted_top; decode enable tracked from CTRL writes
// Notes:   enable follows CTRL writes on the edge the design takes them
`timescale 1ns/1ps
module ted_top_props import ted_pkg::*; #(parameter int WB_ADR_W = 4) (
    // clock and reset
    input wire logic                clk_i,
    input wire logic                rst_i,
    // register bus
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]          wb_sel_i,
    input wire logic [31:0]         wb_dat_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    // extension stream and scheduler
    input wire logic                window_start_i,
    input wire logic                slot_start_i,
    input wire logic                ext_valid_i,
    input wire logic [31:0]         ext_word_i,
    input wire logic                ext_ready_o,
    input wire logic [MAX_LEN_W-1:0] max_slot_tx_length_o,
    input wire logic                max_len_valid_o,
    input wire logic                query_valid_i,
    input wire logic [ID_W-1:0]     query_id_i,
    input wire logic                query_done_o,
    input wire logic                query_allow_o
);
    logic en_reg;
    logic tk;
    logic t3;
    logic t4;
    assign tk = ext_valid_i && ext_ready_o && en_reg;
    assign t3 = tk && ext_word_i[31:27] == TYPE_MAX_LEN;
    assign t4 = tk && ext_word_i[31:27] == TYPE_NODE_LIST;
    always_ff @(posedge clk_i) begin
        if (rst_i) en_reg <= CTRL_EN_RST;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
                 && wb_adr_i[3:2] == 2'h0 && wb_sel_i[0])
            en_reg <= wb_dat_i[CTRL_EN_BIT];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_len_load; t3 && !window_start_i |=>
        max_slot_tx_length_o == $past(ext_word_i[MAX_LEN_W-1:0]) && max_len_valid_o; endproperty
    a_len_load: assert property (p_len_load) else $error("length not loaded");
    property p_len_hold; !t3 |=> $stable(max_slot_tx_length_o); endproperty
    a_len_hold: assert property (p_len_hold) else $error("length moved");
    property p_window; window_start_i && !ext_valid_i |=> !max_len_valid_o; endproperty
    a_window: assert property (p_window) else $error("valid kept");
    property p_slot; slot_start_i |-> !ext_ready_o ##1 !ext_ready_o [*8]; endproperty
    a_slot: assert property (p_slot) else $error("ready during clear");
    property p_byte_busy; t4 && !ext_word_i[FMT_BIT] |=> !ext_ready_o [*2]; endproperty
    a_byte_busy: assert property (p_byte_busy) else $error("byte map busy");
    property p_bit_busy; t4 && ext_word_i[FMT_BIT] |=> !ext_ready_o [*8]; endproperty
    a_bit_busy: assert property (p_bit_busy) else $error("bit map busy");
    property p_qdone; query_valid_i |-> ##2 query_done_o; endproperty
    a_qdone: assert property (p_qdone) else $error("query late");
    property p_qcause; query_done_o |-> $past(query_valid_i, 2); endproperty
    a_qcause: assert property (p_qcause) else $error("stray done");
    property p_allow; !query_done_o |-> $stable(query_allow_o); endproperty
    a_allow: assert property (p_allow) else $error("allow moved");
endmodule // ted_top_props
bind ted_top ted_top_props #(.WB_ADR_W(WB_ADR_W)) u_props (.*);

// file: sim/ted_master_model.sv
// Purpose: domain master offering extension words and descriptor strobes
// Assumes: ext_ready_i is the decoder's combinational ready
// Notes:   junk flag puts ones in reserved bits on command
`timescale 1ns/1ps
module ted_master_model import ted_pkg::*; (
    input  wire logic  clk_i,
    input  wire logic  ext_ready_i,
    output logic       window_start_o = 1'b0,
    output logic       slot_start_o = 1'b0,
    output logic       ext_valid_o = 1'b0,
    output logic [31:0] ext_word_o = 32'h0
);
    function automatic logic [31:0] len_word(input logic [17:0] len, input logic junk);
        return {TYPE_MAX_LEN, junk ? 9'h1FF : 9'h000, len};
    endfunction
    function automatic logic [31:0] list_word(input logic [7:0] o2, o1, input logic fmt, pol, junk);
        return {TYPE_NODE_LIST, junk ? 3'h7 : 3'h0, o2, o1, junk ? 6'h3F : 6'h00, fmt, pol};
    endfunction
    task automatic send(input logic [31:0] w);
        @(posedge clk_i);
        ext_valid_o <= 1'b1;
        ext_word_o  <= w;
        do @(posedge clk_i); while (ext_ready_i !== 1'b1);
        ext_valid_o <= 1'b0;
        ext_word_o  <= ~w; // released word must not look valid
    endtask
    task automatic pulse(input logic slot);
        @(posedge clk_i);
        slot_start_o   <= slot;
        window_start_o <= !slot;
        @(posedge clk_i);
        slot_start_o   <= 1'b0;
        window_start_o <= 1'b0;
    endtask
endmodule // ted_master_model

// file: sim/tb_ted_top.sv
// Purpose: self-checking bench of the extension decoder
// Assumes: 100 MHz clock, reset held 16 cycles
// Notes:   expectations derived from the extension bit layout
`timescale 1ns/1ps
module tb_ted_top import ted_pkg::*; ;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [3:0]  wb_adr = 4'h0;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        win_st;
    logic        slot_st;
    logic        ext_v;
    logic [31:0] ext_w;
    logic        ext_rdy;
    logic [17:0] mlen;
    logic        mlen_v;
    logic        qv = 1'b0;
    logic [7:0]  qid = 8'h00;
    logic        qdone;
    logic        qallow;
    logic [31:0] rd;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    always #5 clk_i = ~clk_i;
    ted_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .window_start_i(win_st), .slot_start_i(slot_st),
        .ext_valid_i(ext_v), .ext_word_i(ext_w), .ext_ready_o(ext_rdy),
        .max_slot_tx_length_o(mlen), .max_len_valid_o(mlen_v), .query_valid_i(qv),
        .query_id_i(qid), .query_done_o(qdone), .query_allow_o(qallow));
    ted_master_model pm (.clk_i(clk_i), .ext_ready_i(ext_rdy), .window_start_o(win_st),
        .slot_start_o(slot_st), .ext_valid_o(ext_v), .ext_word_o(ext_w));
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, sel, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= adr;
        wb_sel  <= sel;
        wb_wdat <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic q(input logic [7:0] id, input logic exp);
        @(posedge clk_i);
        qv  <= 1'b1;
        qid <= id;
        @(posedge clk_i);
        qv <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk(qdone, 1'b1);
        chk(qallow, exp);
    endtask
    task automatic settle;
        do @(negedge clk_i); while (ext_rdy !== 1'b1);
    endtask
    task automatic t_reg;
        wb(1'b0, REG_CTRL, 4'hF, 32'h0);
        chk(rd, 32'h1);
        wb(1'b1, REG_MAX_LEN, 4'hF, 32'h12345); // read-only place
        wb(1'b0, REG_MAX_LEN, 4'hF, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, REG_CTRL, 4'hE, 32'h0);
        wb(1'b0, REG_CTRL, 4'hF, 32'h0);
        chk(rd, 32'h1);
        wb(1'b1, REG_CTRL, 4'hF, 32'h0);
        pm.send(pm.len_word(18'h00055, 1'b0));
        repeat (2) @(negedge clk_i);
        chk(mlen_v, 1'b0);
        wb(1'b1, REG_CTRL, 4'hF, 32'h1);
        $display("t_reg done");
    endtask
    task automatic t_len;
        pm.send(pm.len_word(18'h3FFFF, 1'b1));
        repeat (2) @(negedge clk_i);
        chk(mlen, 18'h3FFFF);
        chk(mlen_v, 1'b1);
        wb(1'b0, REG_MAX_LEN, 4'hF, 32'h0);
        chk(rd, 32'h0003FFFF);
        pm.send(32'h28000001);
        repeat (2) @(negedge clk_i);
        chk(mlen, 18'h3FFFF);
        pm.pulse(1'b0);
        @(negedge clk_i);
        chk(mlen_v, 1'b0);
        $display("t_len done");
    endtask
    task automatic t_byte;
        pm.pulse(1'b1);
        pm.send(pm.list_word(8'd250, 8'd5, 1'b0, 1'b0, 1'b0));
        pm.send(pm.list_word(8'hFF, 8'd251, 1'b0, 1'b0, 1'b1));
        pm.send(pm.list_word(8'hFF, 8'd0, 1'b0, 1'b0, 1'b0));
        settle;
        q(8'd5, 1'b1);
        q(8'd250, 1'b1);
        q(8'd0, 1'b1);
        q(8'd6, 1'b0);
        q(8'd251, 1'b0);
        q(8'd255, 1'b0);
        wb(1'b0, REG_COUNT, 4'hF, 32'h0);
        chk(rd, 32'h00010003);
        $display("t_byte done");
    endtask
    task automatic t_bit;
        pm.pulse(1'b1);
        q(8'd5, 1'b1);
        pm.send(pm.list_word(8'h1A, 8'd245, 1'b1, 1'b1, 1'b0));
        settle;
        q(8'd246, 1'b0);
        q(8'd247, 1'b1);
        q(8'd248, 1'b0);
        q(8'd251, 1'b1);
        q(8'd5, 1'b1);
        wb(1'b0, REG_STATUS, 4'hF, 32'h0);
        chk(rd, 32'h16);
        wb(1'b0, REG_COUNT, 4'hF, 32'h0);
        chk(rd, 32'h2);
        $display("t_bit done");
    endtask
    task automatic t_clr;
        wb(1'b1, REG_CTRL, 4'hF, 32'h3);
        settle;
        wb(1'b0, REG_STATUS, 4'hF, 32'h0);
        chk(rd, 32'h10);
        pm.send(pm.list_word(8'hFE, 8'd0, 1'b1, 1'b0, 1'b0));
        settle;
        q(8'd1, 1'b1);
        q(8'd2, 1'b0);
        pm.send(pm.list_word(8'hFE, 8'd0, 1'b1, 1'b0, 1'b0));
        pm.pulse(1'b1);
        settle;
        q(8'd2, 1'b1);
        wb(1'b0, REG_COUNT, 4'hF, 32'h0);
        chk(rd, 32'h0);
        $display("t_clr done");
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        settle;
        t_reg;
        t_len;
        t_byte;
        t_bit;
        t_clr;
        results();
    end
endmodule // tb_ted_top
